// ---- hw/cpsc_chan_seq.sv ----
// one channel power sequencer: status follows request after settling
// assumes target is driven from a flop on the same clock
`timescale 1ns/100ps
`default_nettype none

module cpsc_chan_seq import cpsc_pkg::*; #(
	parameter int SETTLE_CYCLES = CH_SETTLE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request and settled state
	input wire logic target,
	output logic powered_q
);

	localparam int CW = $clog2(SETTLE_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);
	localparam logic [CW-1:0] ZERO = '0;
	localparam logic [CW-1:0] ONE = CW'(1);

	cpsc_seq_e state_q;
	logic [CW-1:0] cnt_q;

	// ****************************************
	// settling sequence
	// ****************************************
	// a request withdrawn mid-ramp aborts; the state never flips early
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= SEQ_IDLE;
			cnt_q <= ZERO;
		end else begin
			case (state_q)
				SEQ_IDLE: begin
					cnt_q <= ZERO;
					if (target != powered_q)
						state_q <= SEQ_RAMP;
				end
				SEQ_RAMP: begin
					if (target == powered_q || cnt_q == LAST) begin
						state_q <= SEQ_IDLE;
						cnt_q <= ZERO;
					end else begin
						cnt_q <= cnt_q + ONE;
					end
				end
				default: begin
					state_q <= SEQ_IDLE;
					cnt_q <= ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			powered_q <= 1'b0;
		else if (state_q == SEQ_RAMP && target != powered_q && cnt_q == LAST)
			powered_q <= target;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ramp_end;
		state_q == SEQ_RAMP && cnt_q == LAST && target != powered_q;
	endsequence

	sequence s_ramp_mid;
		state_q == SEQ_RAMP && cnt_q != LAST;
	endsequence

	a_settle_done: assert property (s_ramp_end |=> powered_q == $past(target))
		else $error("channel state did not settle to request");
	a_settle_hold: assert property (s_ramp_mid |=> $stable(powered_q))
		else $error("channel state changed before settling");
	a_idle_hold: assert property (
		state_q == SEQ_IDLE |=> $stable(powered_q))
		else $error("channel state changed without a ramp");

endmodule : cpsc_chan_seq

`default_nettype wire

// ---- hw/cpsc_pkg.sv ----
// channel power and slot control: shared constants and types
// assumes a single 50 MHz clock and an 8-bit byte-addressed register port
package cpsc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_SLOT_EN = 8'h74;
	localparam logic [7:0] ADDR_POWER_UP_CONFIG = 8'h75;
	localparam logic [7:0] ADDR_PWR_STS = 8'h76;
	localparam logic [7:0] RST_SLOT_EN = 8'h00;
	localparam logic [7:0] RST_POWER_UP_CONFIG = 8'h00;
	localparam logic [7:0] RST_PWR_STS = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// ****************************************
	// power configuration fields
	// ****************************************
	localparam int BIT_BIAS_ON = 7;
	localparam int BIT_CONV_ON = 6;
	localparam int BIT_PLL_ON = 5;
	localparam int BIT_DYN_ON = 4;
	localparam int BIT_GRP_HI = 3;
	localparam int BIT_GRP_LO = 2;
	localparam int BIT_RSV_RW = 1;
	localparam int BIT_RSV_RO = 0;
	// writable field bits; bit 0 always reads zero
	localparam logic [7:0] CFG_WR_MASK = 8'hfe;

	// ****************************************
	// dynamic group masks, channel 1 at bit 7
	// ****************************************
	localparam logic [1:0] GRP_1_2 = 2'h0;
	localparam logic [1:0] GRP_1_4 = 2'h1;
	localparam logic [1:0] GRP_1_6 = 2'h2;
	localparam logic [7:0] MASK_1_2 = 8'hc0;
	localparam logic [7:0] MASK_1_4 = 8'hf0;
	localparam logic [7:0] MASK_1_6 = 8'hfc;
	localparam logic [7:0] MASK_1_8 = 8'hff;
	localparam logic [7:0] MASK_NONE = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int CH_SETTLE_NS = 10000;
	localparam int CH_SETTLE_CYCLES =
		(CH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic {SEQ_IDLE, SEQ_RAMP} cpsc_seq_e;

	function automatic logic [7:0] cpsc_group_mask(input logic [1:0] sel);
		case (sel)
			GRP_1_2: cpsc_group_mask = MASK_1_2;
			GRP_1_4: cpsc_group_mask = MASK_1_4;
			GRP_1_6: cpsc_group_mask = MASK_1_6;
			default: cpsc_group_mask = MASK_1_8;
		endcase
	endfunction : cpsc_group_mask

endpackage : cpsc_pkg

// ---- hw/cpsc_regs.sv ----
// channel power and slot control register bank
// assumes register port and input enables come from logic on clk
`timescale 1ns/100ps
`default_nettype none

module cpsc_regs import cpsc_pkg::*; #(
	parameter int NUM_CH = 8,
	parameter int SETTLE_CYCLES = CH_SETTLE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// per-channel enables from the input channel enable register
	input wire logic [NUM_CH-1:0] input_channel_enables,
	// power and slot controls, channel 1 at the top bit
	output logic [NUM_CH-1:0] slot_drive_en,
	output logic bias_supply_on,
	output logic clock_multiplier_on,
	output logic [NUM_CH-1:0] channel_power_on,
	output logic [NUM_CH-1:0] channel_power_state
);

	logic [7:0] slot_q;
	logic [7:0] cfg_q;
	logic [7:0] rdata_q;
	logic [NUM_CH-1:0] target_q;
	logic [NUM_CH-1:0] target_d;
	logic [NUM_CH-1:0] powered;
	logic [NUM_CH-1:0] allow;
	logic [NUM_CH-1:0] grp_mask;
	logic conv_on;
	logic dyn_on;
	logic recording;
	logic wr_slot;
	logic wr_cfg;
	logic rd_any;

	assign wr_slot = reg_wr && reg_addr == ADDR_SLOT_EN;
	assign wr_cfg = reg_wr && reg_addr == ADDR_POWER_UP_CONFIG;
	assign rd_any = reg_rd;
	assign conv_on = cfg_q[BIT_CONV_ON];
	assign dyn_on = cfg_q[BIT_DYN_ON];
	assign grp_mask = NUM_CH'(cpsc_group_mask(cfg_q[BIT_GRP_HI:BIT_GRP_LO]));
	// any channel up counts as recording
	assign recording = |powered;

	// ****************************************
	// writable registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst)
			slot_q <= RST_SLOT_EN;
		else if (wr_slot)
			slot_q <= reg_wdata;
	end

	// bit 0 is never stored so it always reads zero
	always_ff @(posedge clk) begin
		if (rst)
			cfg_q <= RST_POWER_UP_CONFIG;
		else if (wr_cfg)
			cfg_q <= reg_wdata & CFG_WR_MASK;
	end

	assign slot_drive_en = slot_q[NUM_CH-1:0];
	assign bias_supply_on = cfg_q[BIT_BIAS_ON];
	assign clock_multiplier_on = cfg_q[BIT_PLL_ON];

	// ****************************************
	// channel power requests
	// ****************************************
	// with converters on, a channel may move when idle overall, or when inside the dynamic group; converters off clear every request
	always_comb begin
		if (!recording)
			allow = '1;
		else if (dyn_on)
			allow = grp_mask;
		else
			allow = '0;
		if (conv_on)
			target_d = (target_q & ~allow) |
				(input_channel_enables & allow);
		else
			target_d = '0;
	end

	always_ff @(posedge clk) begin
		if (rst)
			target_q <= '0;
		else
			target_q <= target_d;
	end

	assign channel_power_on = target_q;

	// ****************************************
	// per-channel settling and status
	// ****************************************
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		cpsc_chan_seq #(
			.SETTLE_CYCLES(SETTLE_CYCLES)
		) u_seq (
			.clk(clk),
			.rst(rst),
			.target(target_q[i]),
			.powered_q(powered[i])
		);
	end

	// low two bits are the PDM-only channels 7 and 8
	assign channel_power_state = powered;

	// ****************************************
	// read path
	// ****************************************
	// writes to the status address fall through every decode above
	always_ff @(posedge clk) begin
		if (rst)
			rdata_q <= RST_PWR_STS;
		else if (rd_any) begin
			case (reg_addr)
				ADDR_SLOT_EN: rdata_q <= slot_q;
				ADDR_POWER_UP_CONFIG: rdata_q <= cfg_q;
				ADDR_PWR_STS: rdata_q <= 8'(powered);
				default: rdata_q <= RD_UNMAPPED;
			endcase
		end
	end

	assign reg_rdata = rdata_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_cfg_write;
		wr_cfg;
	endsequence

	sequence s_frozen;
		conv_on && !dyn_on && recording && !wr_cfg;
	endsequence

	sequence s_rd_unmapped;
		reg_rd && reg_addr != ADDR_SLOT_EN && reg_addr != ADDR_POWER_UP_CONFIG &&
		reg_addr != ADDR_PWR_STS;
	endsequence

	a_slot_write: assert property (
		wr_slot |=> slot_drive_en == $past(reg_wdata[NUM_CH-1:0]))
		else $error("slot enables did not take written value");
	a_slot_reset: assert property (
		$fell(rst) |-> slot_drive_en == '0 && target_q == '0)
		else $error("slot enables not zero after reset");
	a_bias_ctrl: assert property (
		s_cfg_write |=> bias_supply_on == $past(reg_wdata[BIT_BIAS_ON]))
		else $error("bias supply control mismatch");
	a_pll_ctrl: assert property (
		s_cfg_write |=> clock_multiplier_on == $past(reg_wdata[BIT_PLL_ON]))
		else $error("clock multiplier control mismatch");
	a_conv_off: assert property (
		!conv_on && !wr_cfg |=> channel_power_on == '0)
		else $error("channels requested while converters off");
	a_idle_follow: assert property (
		conv_on && !recording && !wr_cfg |=>
		channel_power_on == $past(input_channel_enables))
		else $error("idle request does not follow enables");
	a_frozen_hold: assert property (
		s_frozen |=> $stable(channel_power_on))
		else $error("channel request changed while recording");
	a_dyn_group: assert property (
		conv_on && dyn_on && recording && !wr_cfg |=>
		(channel_power_on & $past(grp_mask)) ==
		($past(input_channel_enables) & $past(grp_mask)))
		else $error("dynamic group does not follow enables");
	a_rsv_zero: assert property (
		reg_rd && reg_addr == ADDR_POWER_UP_CONFIG |=> reg_rdata[BIT_RSV_RO] == 1'b0)
		else $error("reserved read-only bit reads one");
	a_rsv_write: assert property (
		s_cfg_write |=> cfg_q[BIT_RSV_RW] == $past(reg_wdata[BIT_RSV_RW]))
		else $error("reserved writable bit did not take written value");
	a_sts_read: assert property (
		reg_rd && reg_addr == ADDR_PWR_STS |=>
		reg_rdata == 8'($past(channel_power_state)))
		else $error("status read mismatch");
	a_slot_hold: assert property (
		!wr_slot |=> $stable(slot_drive_en))
		else $error("slot enables changed without a write");
	a_cfg_hold: assert property (
		!wr_cfg |=> $stable(cfg_q))
		else $error("power configuration changed without a write");
	a_rd_unmapped: assert property (
		s_rd_unmapped |=> reg_rdata == RD_UNMAPPED)
		else $error("unmapped read returned nonzero data");
	a_rd_hold: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

endmodule : cpsc_regs

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the channel power and slot control registers
// assumes cpsc_pkg is compiled first; the bench drives every port itself
`timescale 1ns/100ps
`default_nettype none

module testbench import cpsc_pkg::*;;

	// ****************************************
	// signals and design
	// ****************************************
	// short settle keeps the run brief; expectations use this value
	localparam int SETTLE = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] input_channel_enables = 8'h00;
	logic [7:0] reg_rdata, slot_drive_en, channel_power_on;
	logic [7:0] channel_power_state;
	logic bias_supply_on, clock_multiplier_on;
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	cpsc_regs #(.NUM_CH(8), .SETTLE_CYCLES(SETTLE)) dut_u (
		.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.input_channel_enables(input_channel_enables),
		.slot_drive_en(slot_drive_en), .bias_supply_on(bias_supply_on),
		.clock_multiplier_on(clock_multiplier_on),
		.channel_power_on(channel_power_on),
		.channel_power_state(channel_power_state)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic results();
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(negedge clk);
	endtask : wr_reg

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(reg_rdata, exp, "read data");
	endtask : rd_check

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask : settle

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rd_check(8'h74, 8'h00);
		rd_check(8'h75, 8'h00);
		rd_check(8'h76, 8'h00);
		rd_check(8'h80, 8'h00);
		check({bias_supply_on, clock_multiplier_on, 6'h00}, 8'h00, "pwr");
	endtask : t_reset

	task automatic t_slots();
		for (int i = 0; i < 8; i++) begin
			wr_reg(8'h74, 8'h80 >> i);
			check(slot_drive_en, 8'h80 >> i, "slot");
			rd_check(8'h74, 8'h80 >> i);
		end
		wr_reg(8'h74, 8'h00);
		check(slot_drive_en, 8'h00, "slot off");
	endtask : t_slots

	task automatic t_cfg();
		wr_reg(8'h75, 8'hbc);
		check({bias_supply_on, clock_multiplier_on, 6'h00}, 8'hc0, "on");
		rd_check(8'h75, 8'hbc);
		settle(2);
		check(channel_power_on, 8'h00, "conv off");
		wr_reg(8'h75, 8'h00);
		check({bias_supply_on, clock_multiplier_on, 6'h00}, 8'h00, "off");
	endtask : t_cfg

	task automatic t_power();
		@(posedge clk) input_channel_enables <= 8'ha5;
		wr_reg(8'h75, 8'h40);
		settle(1);
		check(channel_power_on, 8'ha5, "request");
		check(channel_power_state, 8'h00, "early state");
		wr_reg(8'h76, 8'hff);
		settle(SETTLE + 4);
		check(channel_power_state, 8'ha5, "state");
		rd_check(8'h76, 8'ha5);
	endtask : t_power

	task automatic t_dynamic();
		logic [7:0] masks [4];
		logic [7:0] exp;
		masks = '{8'hc0, 8'hf0, 8'hfc, 8'hff};
		exp = 8'ha5;
		@(posedge clk) input_channel_enables <= 8'hff;
		settle(4);
		check(channel_power_on, exp, "frozen");
		for (int g = 0; g < 4; g++) begin
			wr_reg(8'h75, {4'h5, g[1:0], 2'b00});
			settle(2);
			exp = (exp & ~masks[g]) | masks[g];
			check(channel_power_on, exp, "group");
		end
		// channel 1 stays enabled while the dynamic bit is set
		@(posedge clk) input_channel_enables <= 8'hbf;
		wr_reg(8'h75, 8'h50);
		settle(2);
		check(channel_power_on, 8'hbf, "drop ch2");
		wr_reg(8'h75, 8'h40);
		settle(2);
		check(channel_power_on, 8'hbf, "frozen again");
		wr_reg(8'h75, 8'h00);
		settle(2);
		check(channel_power_on, 8'h00, "all off");
		settle(SETTLE + 4);
		rd_check(8'h76, 8'h00);
	endtask : t_dynamic

	// ****************************************
	// sequence and watchdog
	// ****************************************
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_slots();
		t_cfg();
		t_power();
		t_dynamic();
		results();
	end

endmodule : testbench

`default_nettype wire
